//--- hdl/tpgil_top.sv
/*
  Digital input logic of a three-phase gate predriver: enable gating,
  phase request decode, deadtime and interlock, midpoint flags and the
  serial setup port.
  Assumes pins arrive unsynchronised, the serial clock stops outside
  frames, and analog comparators supply the midpoint levels.
*/
`timescale 1ns/10ps
`include "tpgil_map.svh"
module tpgil_top (
  input  wire logic clk_sys,                 // System clock, 100 MHz.
  input  wire logic resetn,                  // Synchronous reset, active low.
  input  wire logic device_reset_n,          // Reset pin, asynchronous, active low.
  input  wire logic enable_one,              // First gate enable.
  input  wire logic enable_two,              // Second gate enable.
  input  wire logic phase_a_high_request_n,  // Phase A high-side request, low active.
  input  wire logic phase_b_high_request_n,  // Phase B high-side request, low active.
  input  wire logic phase_c_high_request_n,  // Phase C high-side request, low active.
  input  wire logic phase_a_low_request,     // Phase A low-side request.
  input  wire logic phase_b_low_request,     // Phase B low-side request.
  input  wire logic phase_c_low_request,     // Phase C low-side request.
  input  wire logic phase_a_source_above,    // Comparator: A source over half supply.
  input  wire logic phase_b_source_above,    // Comparator: B source over half supply.
  input  wire logic phase_c_source_above,    // Comparator: C source over half supply.
  input  wire logic spi_clk,                 // Serial bit clock from the host.
  input  wire logic frame_select_n,          // Frame select, low active.
  input  wire logic serial_in,               // Serial data in.
  output logic      serial_out,              // Serial data out.
  output logic      serial_out_oe,           // Serial out enable, high drives.
  output logic      phase_a_high_gate,       // Phase A high-side drive on.
  output logic      phase_b_high_gate,       // Phase B high-side drive on.
  output logic      phase_c_high_gate,       // Phase C high-side drive on.
  output logic      phase_a_low_gate,        // Phase A low-side drive on.
  output logic      phase_b_low_gate,        // Phase B low-side drive on.
  output logic      phase_c_low_gate,        // Phase C low-side drive on.
  output logic      phase_a_midpoint_flag,   // Phase A midpoint comparator flag.
  output logic      phase_b_midpoint_flag,   // Phase B midpoint comparator flag.
  output logic      phase_c_midpoint_flag    // Phase C midpoint comparator flag.
);
  import tpgil_pkg::*;

  // ****************************************************************
  // Link domain: serial shift on the host's bit clock
  // ****************************************************************
  logic [`TPGIL_CMD_W-1:0] shift;
  logic [`TPGIL_CMD_W-1:0] next_shift;
  logic [2:0]              bit_cnt;
  logic [2:0]              next_bit_cnt;
  logic                    so_bit;
  logic                    next_so_bit;
  logic [`TPGIL_CMD_W-1:0] cmd_hold;
  logic [`TPGIL_CMD_W-1:0] next_cmd_hold;
  logic                    word_toggle;
  logic                    next_word_toggle;
  logic                    word_done;

  // Bits enter at the bottom so the first bit ends at the top.
  always_comb begin
    next_shift   = {shift[`TPGIL_CMD_W-2:0], serial_in};
    next_bit_cnt = 3'(bit_cnt + 3'h1);
    next_so_bit  = cmd_hold[~bit_cnt];                    // Echo last word, top bit first.
  end

  // The frame select clears the frame state; with the bit clock stopped
  // between frames there is no edge that could do it.
  always_ff @(negedge spi_clk or posedge frame_select_n) begin
    if (frame_select_n) begin
      shift   <= '0;
      bit_cnt <= 3'h0;
      so_bit  <= 1'b0;
    end else begin
      shift   <= next_shift;
      bit_cnt <= next_bit_cnt;
      so_bit  <= next_so_bit;
    end
  end

  assign word_done = (bit_cnt == 3'h7);

  // A finished word is held still and announced by a toggle.
  always_comb begin
    next_cmd_hold    = cmd_hold;
    next_word_toggle = word_toggle;
    if (word_done && !frame_select_n) begin
      next_cmd_hold    = next_shift;
      next_word_toggle = ~word_toggle;
    end
  end

  // Only the reset pin resets these, so a frame end cannot fake a word.
  always_ff @(negedge spi_clk or negedge device_reset_n) begin
    if (!device_reset_n) begin
      cmd_hold    <= '0;
      word_toggle <= 1'b0;
    end else begin
      cmd_hold    <= next_cmd_hold;
      word_toggle <= next_word_toggle;
    end
  end

  assign serial_out = so_bit;

  // ****************************************************************
  // Pin synchronisers into the system domain
  // ****************************************************************
  localparam int SW = 14;
  logic [SW-1:0] pins_sync;
  logic          en1_s;
  logic          en2_s;
  logic          pin_rst_n_s;
  logic          sel_s;
  logic          tog_s;
  logic [2:0]    hi_req_n_s;
  logic [2:0]    lo_req_s;
  logic [2:0]    above_s;

  // The select enters inverted, so the synchroniser's reset value is the
  // idle level and the output enable cannot pulse just after reset.
  tpgil_sync #(.W(SW)) u_sync (
    .clk_sys  (clk_sys),
    .resetn   (resetn),
    .async_in ({enable_one, enable_two, device_reset_n, ~frame_select_n, word_toggle,
                phase_c_high_request_n, phase_b_high_request_n, phase_a_high_request_n,
                phase_c_low_request, phase_b_low_request, phase_a_low_request,
                phase_c_source_above, phase_b_source_above, phase_a_source_above}),
    .sync_out (pins_sync)
  );

  assign {en1_s, en2_s, pin_rst_n_s, sel_s, tog_s, hi_req_n_s, lo_req_s, above_s} =
         pins_sync;

  // ****************************************************************
  // Configuration from received words
  // ****************************************************************
  tpgil_cfg_t cfg;
  tpgil_cfg_t next_cfg;
  logic       tog_seen;
  logic       next_tog_seen;
  logic       so_oe;
  logic       next_so_oe;
  logic [1:0] opcode;

  assign opcode = cmd_hold[`TPGIL_OP_MSB:`TPGIL_OP_LSB];

  // The held word is read only after its toggle has crossed, by which
  // time it has been still for two system clocks.
  always_comb begin
    next_cfg      = cfg;
    next_tog_seen = tog_s;
    next_so_oe    = sel_s;
    if (!pin_rst_n_s) begin
      next_cfg.deadtime = `TPGIL_DT_RESET;
      next_cfg.override = `TPGIL_OVR_RESET;
    end else if (tog_s != tog_seen) begin
      if (opcode == `TPGIL_OP_DEADTIME) begin
        next_cfg.deadtime = cmd_hold[`TPGIL_DT_MSB:`TPGIL_DT_LSB];
      end else if (opcode == `TPGIL_OP_MODE &&
                   cmd_hold[`TPGIL_KEY_MSB:`TPGIL_KEY_LSB] == `TPGIL_MODE_KEY) begin
        next_cfg.override = cmd_hold[`TPGIL_OVR_BIT];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      cfg.deadtime <= `TPGIL_DT_RESET;
      cfg.override <= `TPGIL_OVR_RESET;
      tog_seen     <= 1'b0;
      so_oe        <= 1'b0;
    end else begin
      cfg      <= next_cfg;
      tog_seen <= next_tog_seen;
      so_oe    <= next_so_oe;
    end
  end

  assign serial_out_oe = so_oe;

  // ****************************************************************
  // Phase gate control with deadtime and interlock
  // ****************************************************************
  tpgil_req_t   req;
  logic         allow;
  tpgil_state_t state      [3];
  tpgil_state_t next_state [3];
  logic [5:0]   dcnt       [3];
  logic [5:0]   next_dcnt  [3];
  logic [2:0]   gate_hi;
  logic [2:0]   gate_lo;
  logic [2:0]   next_gate_hi;
  logic [2:0]   next_gate_lo;
  logic [2:0]   want_hi;
  logic [2:0]   want_lo;

  assign allow    = en1_s & en2_s & pin_rst_n_s;
  assign req.high = ~hi_req_n_s;
  assign req.low  = lo_req_s;

  // Both requests at once cancel each other unless overridden.
  assign want_hi = req.high & {3{allow}} & ({3{cfg.override}} | ~req.low);
  assign want_lo = req.low  & {3{allow}} & ({3{cfg.override}} | ~req.high);

  for (genvar p = 0; p < 3; p++) begin : g_phase
    // A side that turns off waits out the deadtime before either side
    // may turn on; override trades that safety for direct control.
    always_comb begin
      next_state[p] = state[p];
      next_dcnt[p]  = dcnt[p];
      unique case (state[p])
        TPGIL_OFF: begin
          if (want_hi[p]) begin
            next_state[p] = TPGIL_HIGH;
          end else if (want_lo[p]) begin
            next_state[p] = TPGIL_LOW;
          end
        end
        TPGIL_HIGH: begin
          if (!want_hi[p]) begin
            next_state[p] = TPGIL_DEAD;
            next_dcnt[p]  = cfg.deadtime;
          end
        end
        TPGIL_LOW: begin
          if (!want_lo[p]) begin
            next_state[p] = TPGIL_DEAD;
            next_dcnt[p]  = cfg.deadtime;
          end
        end
        TPGIL_DEAD: begin
          if (dcnt[p] == `TPGIL_DT_ZERO) begin
            next_state[p] = TPGIL_OFF;
          end else begin
            next_dcnt[p] = 6'(dcnt[p] - `TPGIL_DT_ONE);
          end
        end
        default: begin
          next_state[p] = TPGIL_OFF;
        end
      endcase
      if (cfg.override) begin
        next_gate_hi[p] = want_hi[p];
        next_gate_lo[p] = want_lo[p];
      end else begin
        next_gate_hi[p] = (next_state[p] == TPGIL_HIGH) && allow;
        next_gate_lo[p] = (next_state[p] == TPGIL_LOW) && allow;
      end
    end

    always_ff @(posedge clk_sys) begin
      if (!resetn) begin
        state[p]   <= TPGIL_OFF;
        dcnt[p]    <= `TPGIL_DT_ZERO;
        gate_hi[p] <= 1'b0;
        gate_lo[p] <= 1'b0;
      end else begin
        state[p]   <= next_state[p];
        dcnt[p]    <= next_dcnt[p];
        gate_hi[p] <= next_gate_hi[p];
        gate_lo[p] <= next_gate_lo[p];
      end
    end
  end

  assign phase_a_high_gate = gate_hi[0];
  assign phase_b_high_gate = gate_hi[1];
  assign phase_c_high_gate = gate_hi[2];
  assign phase_a_low_gate  = gate_lo[0];
  assign phase_b_low_gate  = gate_lo[1];
  assign phase_c_low_gate  = gate_lo[2];

  // ****************************************************************
  // Midpoint flags
  // ****************************************************************
  logic [2:0] mid;
  logic [2:0] next_mid;

  // The output is always driven; low means the source is below half supply.
  always_comb begin
    next_mid = above_s;
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      mid <= 3'h0;
    end else begin
      mid <= next_mid;
    end
  end

  assign phase_a_midpoint_flag = mid[0];
  assign phase_b_midpoint_flag = mid[1];
  assign phase_c_midpoint_flag = mid[2];

endmodule : tpgil_top

//--- include/tpgil_map.svh
/*
  Constants of the three-phase gate input logic: command layout, field
  positions and reset values.
  Assumes it is included by its bare name from a design file.
*/
`ifndef TPGIL_MAP_SVH
`define TPGIL_MAP_SVH

// ****************************************************************
// Serial command layout
// ****************************************************************
`define TPGIL_CMD_W        8
`define TPGIL_OP_MSB       7
`define TPGIL_OP_LSB       6
`define TPGIL_OP_DEADTIME  2'h1
`define TPGIL_OP_MODE      2'h2
`define TPGIL_KEY_MSB      5
`define TPGIL_KEY_LSB      1
`define TPGIL_MODE_KEY     5'h15
`define TPGIL_OVR_BIT      0
`define TPGIL_DT_MSB       5
`define TPGIL_DT_LSB       0

// ****************************************************************
// Reset values and deadtime count constants
// ****************************************************************
`define TPGIL_DT_RESET     6'h04
`define TPGIL_OVR_RESET    1'h0
`define TPGIL_DT_ZERO      6'h00
`define TPGIL_DT_ONE       6'h01

`endif

//--- include/tpgil_pkg.sv
/*
  Types shared by the three-phase gate input logic.
  Assumes nothing of its surroundings.
*/
package tpgil_pkg;

  // Per-phase gate state, one-hot.
  typedef enum logic [3:0] {
    TPGIL_OFF  = 4'b0001,
    TPGIL_HIGH = 4'b0010,
    TPGIL_LOW  = 4'b0100,
    TPGIL_DEAD = 4'b1000
  } tpgil_state_t;

  // Configuration loaded from serial commands.
  typedef struct packed {
    logic [5:0] deadtime;
    logic       override;
  } tpgil_cfg_t;

  // Phase requests after synchronisation, active high on both sides.
  typedef struct packed {
    logic [2:0] high;
    logic [2:0] low;
  } tpgil_req_t;

endpackage : tpgil_pkg

//--- hdl/tpgil_sync.sv
/*
  Two-flip-flop synchroniser for a group of independent levels.
  Assumes each bit is a level that may change at any time.
*/
`timescale 1ns/10ps
module tpgil_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_sys,  // System clock.
  input  wire logic         resetn,   // Synchronous reset, active low.
  input  wire logic [W-1:0] async_in, // Levels from another domain.
  output logic      [W-1:0] sync_out  // Levels safe to read.
);

  logic [W-1:0] meta;

  // The first stage feeds only the second stage.
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      meta     <= '0;
      sync_out <= '0;
    end else begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end

endmodule : tpgil_sync

//--- verification/tpgil_host_model.sv
/* Host model: frames two-word commands on the serial port.
   Assumes the bench resolves the serial out wire from its enable. */
`timescale 1ns/10ps
module tpgil_host_model (
  output logic      spi_clk,        // Bit clock, still outside frames.
  output logic      frame_select_n, // Frame select, low active.
  output logic      serial_in,      // Command bits.
  input  wire logic so_line         // Resolved serial out wire.
);
  // ******************
  // Serial transfers
  // ******************
  // Clock and data idle and the select low at time zero; the select rises at 1 ns so the design sees
  // a real edge that clears its frame state.
  initial begin
    spi_clk = 1'b0;
    frame_select_n = 1'b0;
    serial_in = 1'b0;
    #1 frame_select_n = 1'b1;
  end

  // Two words a frame; bits change mid-low so the falling edge sees them
  // settled, and the reply is read 16 ns after each falling edge.
  task automatic xfer(input logic [15:0] w, output logic [15:0] rd);
    frame_select_n = 1'b0;
    #64;
    for (int i = 15; i >= 0; i--) begin
      serial_in = w[i];
      #32 spi_clk = 1'b1;
      #32 spi_clk = 1'b0;
      #16 rd[i] = so_line;
      #16;
    end
    frame_select_n = 1'b1;
    // A released line shows the inverse, so a stale bit cannot pass.
    serial_in = ~w[0];
    #200;
  endtask : xfer
endmodule : tpgil_host_model

//--- verification/tpgil_monitor.sv
/* Checker of the gate input logic, bound to tpgil_top.
   Assumes pins reach outputs three clk_sys edges after they change. */
`timescale 1ns/10ps
module tpgil_monitor (
  input wire logic clk_sys,                // Clock.
  input wire logic resetn,                 // Reset, low active.
  input wire logic enable_one,             // Enable.
  input wire logic enable_two,             // Enable.
  input wire logic phase_a_high_request_n, // Request.
  input wire logic phase_a_low_request,    // Request.
  input wire logic phase_a_source_above,   // Comparator.
  input wire logic frame_select_n,         // Select.
  input wire logic serial_out,             // Serial out.
  input wire logic serial_out_oe,          // Its enable.
  input wire logic phase_a_high_gate,      // Gate.
  input wire logic phase_b_high_gate,      // Gate.
  input wire logic phase_c_high_gate,      // Gate.
  input wire logic phase_a_low_gate,       // Gate.
  input wire logic phase_b_low_gate,       // Gate.
  input wire logic phase_c_low_gate,       // Gate.
  input wire logic phase_a_midpoint_flag   // Flag.
);
  // ******************
  // Pin relations
  // ******************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  logic       any_gate;
  logic [2:0] age;
  logic [2:0] next_age;

  // Any gate on.
  assign any_gate = phase_a_high_gate | phase_b_high_gate | phase_c_high_gate |
                    phase_a_low_gate | phase_b_low_gate | phase_c_low_gate;

  // Edges since reset; $past still sees reset-era pins before it is full.
  always_comb begin
    next_age = (age == 3'h7) ? age : age + 3'h1;
    if (!resetn) begin
      next_age = 3'h0;
    end
  end
  always_ff @(posedge clk_sys) begin
    age <= next_age;
  end

  sequence s_low_drop;
    $fell(phase_a_low_gate);
  endsequence
  sequence s_high_quiet;
    !phase_a_high_gate [*2];
  endsequence

  a_enables_off: assert property ((!(enable_one && enable_two)) [*3] |=> !any_gate)
    else $error("gate on with an enable low");
  a_high_cause: assert property (phase_a_high_gate |-> $past(enable_one, 3) &&
    $past(enable_two, 3) && !$past(phase_a_high_request_n, 3))
    else $error("high gate without request");
  a_low_cause: assert property (phase_a_low_gate |-> $past(enable_one, 3) &&
    $past(enable_two, 3) && $past(phase_a_low_request, 3))
    else $error("low gate without request");
  a_no_overlap: assert property (!(phase_a_high_gate && phase_a_low_gate) &&
    !(phase_b_high_gate && phase_b_low_gate) && !(phase_c_high_gate && phase_c_low_gate))
    else $error("both gates of a phase on");
  a_dead_gap: assert property (s_low_drop |-> s_high_quiet)
    else $error("no dead gap after low side");
  a_flag_follows: assert property (age == 3'h7 |->
    phase_a_midpoint_flag == $past(phase_a_source_above, 3))
    else $error("midpoint flag wrong");
  a_oe_idle: assert property (frame_select_n [*5] |-> !serial_out_oe)
    else $error("serial out driven while idle");
  a_oe_selected: assert property ((!frame_select_n) [*5] ##0 age == 3'h7 |-> serial_out_oe)
    else $error("serial out not driven in frame");
  a_out_quiet: assert property (frame_select_n [*2] |-> !serial_out)
    else $error("serial out not cleared");
endmodule : tpgil_monitor

bind tpgil_top tpgil_monitor i_tpgil_monitor (.clk_sys, .resetn, .enable_one, .enable_two,
  .phase_a_high_request_n, .phase_a_low_request, .phase_a_source_above, .frame_select_n,
  .serial_out, .serial_out_oe, .phase_a_high_gate, .phase_b_high_gate, .phase_c_high_gate,
  .phase_a_low_gate, .phase_b_low_gate, .phase_c_low_gate, .phase_a_midpoint_flag);

//--- verification/tpgil_top_bench.sv
/* Bench of the gate input logic: enables, requests, flags, deadtime setup.
   Assumes the host model and the bound monitor are compiled with it. */
`timescale 1ns/10ps
module tpgil_top_bench;
  // ******************
  // Harness
  // ******************
  logic        clk_sys = 1'b0;
  logic        resetn = 1'b0;
  logic        device_reset_n = 1'b1;
  logic [1:0]  en = 2'h0;
  logic [2:0]  hreq_n = 3'h7;
  logic [2:0]  lreq = 3'h0;
  logic [2:0]  src = 3'h0;
  logic [5:0]  gates;
  logic [2:0]  flags;
  logic        serial_out;
  logic        serial_out_oe;
  logic [15:0] rd;
  wire         spi_clk, frame_select_n, serial_in, so_line;
  int          miscompares = 0;
  int          total_checks = 0;
  int          d_def, d_new, d_keep, d_rst;

  // Clock and the resolved serial out wire.
  always #5 clk_sys = ~clk_sys;
  assign so_line = serial_out_oe ? serial_out : 1'bz;

  tpgil_top i_tpgil_top (.clk_sys, .resetn, .device_reset_n, .enable_one(en[1]),
    .enable_two(en[0]), .phase_a_high_request_n(hreq_n[2]),
    .phase_b_high_request_n(hreq_n[1]), .phase_c_high_request_n(hreq_n[0]),
    .phase_a_low_request(lreq[2]), .phase_b_low_request(lreq[1]),
    .phase_c_low_request(lreq[0]), .phase_a_source_above(src[2]),
    .phase_b_source_above(src[1]), .phase_c_source_above(src[0]), .spi_clk,
    .frame_select_n, .serial_in, .serial_out, .serial_out_oe,
    .phase_a_high_gate(gates[5]), .phase_b_high_gate(gates[4]),
    .phase_c_high_gate(gates[3]), .phase_a_low_gate(gates[2]),
    .phase_b_low_gate(gates[1]), .phase_c_low_gate(gates[0]),
    .phase_a_midpoint_flag(flags[2]), .phase_b_midpoint_flag(flags[1]),
    .phase_c_midpoint_flag(flags[0]));
  tpgil_host_model host (.spi_clk, .frame_select_n, .serial_in, .so_line);

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : give_verdict

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Pins change just after an edge; outputs are read 1 ns past the last edge.
  task automatic pins(input logic [1:0] e, input logic [2:0] h, input logic [2:0] l,
                      input int n);
    @(posedge clk_sys);
    en <= e;
    hreq_n <= h;
    lreq <= l;
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : pins

  // Edges from a low-to-high swap on phase A until its high gate is on.
  task automatic measure(output int d);
    pins(2'h3, 3'h7, 3'h4, 40);
    pins(2'h3, 3'h3, 3'h0, 0);
    d = 0;
    while (gates[5] !== 1'b1 && d < 100) begin
      @(posedge clk_sys);
      #1;
      d++;
    end
    if (d >= 100) begin
      miscompares++;
      give_verdict();
    end
  endtask : measure

  // ******************
  // Scenarios
  // ******************
  task automatic t_enables();
    for (int i = 0; i < 4; i++) begin
      pins(i[1:0], 3'h0, 3'h0, 20);
      check("high gates", gates, (i == 3) ? 6'h38 : 6'h00);
    end
  endtask : t_enables

  task automatic t_requests();
    pins(2'h3, 3'h7, 3'h5, 20);
    check("low gates", gates, 6'h05);
    pins(2'h3, 3'h3, 3'h3, 20);
    check("mixed gates", gates, 6'h23);
    pins(2'h3, 3'h3, 3'h4, 20);
    check("both asked", gates, 6'h00);
  endtask : t_requests

  task automatic t_flags();
    for (int i = 0; i < 2; i++) begin
      @(posedge clk_sys);
      src <= i[0] ? 3'h2 : 3'h5;
      repeat (5) @(posedge clk_sys);
      #1;
      check("flags", flags, i[0] ? 3'h2 : 3'h5);
    end
  endtask : t_flags

  // Deadtime 4 by default, 10 after setup; a bad key must change nothing.
  // A swap takes the deadtime plus five edges: two of sync, turn-off, dead exit, turn-on.
  task automatic t_serial();
    measure(d_def);
    check("default dead", d_def, 16'h0009);
    check("oe idle", serial_out_oe, 1'b0);
    host.xfer(16'h4a00, rd);
    check("echo reset", rd, 16'h004a);
    measure(d_new);
    check("dead step", d_new - d_def, 16'h0006);
    host.xfer(16'h95c5, rd);
    check("echo last", rd, 16'h0095);
    measure(d_keep);
    check("refused words", d_keep, d_new);
    @(posedge clk_sys);
    device_reset_n <= 1'b0;
    repeat (6) @(posedge clk_sys);
    device_reset_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    measure(d_rst);
    check("dead reload", d_rst, d_def);
  endtask : t_serial

  // Main sequence after a 12-cycle reset.
  // The reset pin is pulsed inside the system reset, so the link-side
  // word hold and toggle start from known values.
  initial begin
    device_reset_n <= 1'b0;
    repeat (6) @(posedge clk_sys);
    device_reset_n <= 1'b1;
    repeat (6) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (3) @(posedge clk_sys);
    t_enables();
    t_requests();
    t_flags();
    t_serial();
    give_verdict();
  end
endmodule : tpgil_top_bench
